// >>> hdl/pdtc_pkg.sv
// Package for the programmable divider and tune counter.
// Assumes a 100 MHz system clock and classic Wishbone register access.
package pdtc_pkg;

	// Clock rates
	localparam int unsigned CLK_HZ   = 100_000_000;
	localparam int unsigned XTAL_HZ  = 5_000_000;
	localparam int unsigned REF_HZ   = 50_000;
	localparam int unsigned PHASE_HZ = 50;

	// Fixed division ratios derived from the rates
	localparam int unsigned XTAL_DIV  = CLK_HZ / XTAL_HZ;
	localparam int unsigned REF_DIV   = XTAL_HZ / REF_HZ;
	localparam int unsigned PHASE_DIV = REF_HZ / PHASE_HZ;

	// Oscillator prescaler ratio
	localparam int unsigned PRESCALE = 20;

	// Indicator hold time and its cycle count
	localparam int unsigned MONO_US     = 30_000;
	localparam int unsigned MONO_CYCLES = MONO_US * (CLK_HZ / 1_000_000);

	// Decade geometry
	localparam int unsigned DIGITS     = 7;
	localparam int unsigned CMP_DIGITS = 3;

	// Terminal values, halving bit plus seven BCD digits
	localparam logic [27:0] TERM_HIGH_BCD  = 28'h0213999;
	localparam logic        TERM_HIGH_HALF = 1'b1;
	localparam logic [27:0] TERM_LOW_BCD   = 28'h9785999;
	localparam logic        TERM_LOW_HALF  = 1'b0;
	localparam logic [3:0]  BCD_NINE       = 4'h9;

	// Register word offsets (byte addresses)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_DIGITS = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_COUNT  = 4'hc;

	// Control field positions and reset values
	localparam int unsigned CTRL_HOLD_BIT   = 0;
	localparam int unsigned CTRL_HIGHOF_BIT = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	localparam logic [27:0] DIGITS_RESET    = 28'h0000000;

	// Status field positions
	localparam int unsigned STAT_HIGHER_BIT = 0;
	localparam int unsigned STAT_LOWER_BIT  = 1;
	localparam int unsigned STAT_OVF_BIT    = 2;
	localparam int unsigned STAT_HALF_BIT   = 3;

	// Bus response states
	typedef enum logic [0:0] {
		PDTC_BUS_IDLE = 1'b0,
		PDTC_BUS_ACK  = 1'b1
	} pdtc_bus_t;

endpackage

// >>> hdl/pdtc_decade.sv
// Presettable BCD divide-by-ten stage with carry.
// Assumes one synchronous clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pdtc_decade (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Control
	input  wire logic       load,
	input  wire logic [3:0] loadValue,
	input  wire logic       clear,
	input  wire logic       countEn,
	// Result
	output logic      [3:0] digit,
	output logic            carry
);
	import pdtc_pkg::*;

	// Carry as the stage rolls over from nine
	assign carry = countEn && (digit == BCD_NINE);

	// Load, clear, or count; full stage clears itself
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			digit <= 4'h0;
		end else if (load) begin
			digit <= loadValue;
		end else if (clear) begin
			digit <= 4'h0;
		end else if (countEn) begin
			digit <= (digit == BCD_NINE) ? 4'h0 : digit + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/pdtc_divider.sv
// Programmable divider, terminal detector and tune comparison counter.
// Assumes inputs synchronous to mclk and a classic Wishbone master.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Oscillator input edges are divided by twenty before the programmable chain.
// - In hold mode the chain emits 5 Hz pulses at the selected frequency.
// - The 50 Hz phase reference comes from a 5 MHz tick through fixed dividers.
// - Digit switches select frequency in 100 Hz steps.
// - Each division cycle loads the nines' complement of the digits and counts up.
// - Decimal stages are presettable BCD decades loaded with complemented digits.
// - The most significant stage is a single halving flip-flop.
// - Terminal detector recognises 10213999 or 9785999 by offset selection and pulses.
// - Each decade clears itself when full and passes a carry on.
// - Search mode bypasses the lowest decade, giving 50 Hz at the match.
// - In search mode a 3-decade counter plus overflow counts 50 kHz, divider-reset.
// - Gating above 50 Hz clears the counter early; decrease lamp lights.
// - Input below setting toggles overflow, holding the increase lamp on.
// - At the match frequency the two lamps light alternately.
module pdtc_divider #(
	parameter int unsigned MONO_LEN = pdtc_pkg::MONO_CYCLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Receiver oscillator
	input  wire logic        variableOscillatorInput,
	// Phase detector and lamps
	output logic             divPulse,
	output logic             refPulse,
	output logic             tuneHigher,
	output logic             tuneLower
);
	import pdtc_pkg::*;

	// Register state
	logic        holdMode;
	logic        highOffset;
	logic [27:0] digitSwitch;
	pdtc_bus_t   busState;

	// Prescaler and reference chain
	logic        oscPrev;
	logic [4:0]  preCount;
	logic        preTick;
	logic [4:0]  xtalCount;
	logic        xtalTick;
	logic [6:0]  refCount;
	logic        tick50k;
	logic [9:0]  phaseCount;

	// Programmable chain
	logic [27:0] chain;
	logic [6:0]  carry;
	logic [6:0]  stageEn;
	logic        finalHalvingStage;
	logic        atTerm;
	logic [27:0] nineComp;
	logic [27:0] termBcd;
	logic        termHalf;
	logic [27:0] cmpMask;

	// Comparison counter and indicator
	logic [11:0] cmpChain;
	logic [2:0]  cmpCarry;
	logic [2:0]  cmpEn;
	logic        overflow;
	logic        overflowEvt;
	logic [31:0] monoCount;
	logic        searchMode;
	logic        busHit;
	logic        wrHit;
	logic        startLoad;
	logic        chainLoad;

	// Mode and bus decode; writes land at the ack edge
	assign searchMode = !holdMode;
	assign busHit     = cyc_i && stb_i && (busState == PDTC_BUS_IDLE);
	assign wrHit      = cyc_i && stb_i && we_i && ack_o;

	// Wishbone handshake, one wait state then a single ack
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busState <= PDTC_BUS_IDLE;
			ack_o    <= 1'b0;
		end else begin
			case (busState)
				PDTC_BUS_IDLE: begin
					ack_o <= busHit;
					if (busHit) begin
						busState <= PDTC_BUS_ACK;
					end
				end
				PDTC_BUS_ACK: begin
					ack_o    <= 1'b0;
					busState <= PDTC_BUS_IDLE;
				end
				default: begin
					ack_o    <= 1'b0;
					busState <= PDTC_BUS_IDLE;
				end
			endcase
		end
	end

	// Register writes at the ack edge, honouring byte lanes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			holdMode    <= CTRL_RESET[CTRL_HOLD_BIT];
			highOffset  <= CTRL_RESET[CTRL_HIGHOF_BIT];
			digitSwitch <= DIGITS_RESET;
		end else if (wrHit) begin
			if (adr_i == REG_CTRL && sel_i[0]) begin
				holdMode   <= dat_i[CTRL_HOLD_BIT];
				highOffset <= dat_i[CTRL_HIGHOF_BIT];
			end
			if (adr_i == REG_DIGITS) begin
				if (sel_i[0]) begin
					digitSwitch[7:0] <= dat_i[7:0];
				end
				if (sel_i[1]) begin
					digitSwitch[15:8] <= dat_i[15:8];
				end
				if (sel_i[2]) begin
					digitSwitch[23:16] <= dat_i[23:16];
				end
				if (sel_i[3]) begin
					digitSwitch[27:24] <= dat_i[27:24];
				end
			end
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dat_o <= 32'h0;
		end else if (busHit && !we_i) begin
			case (adr_i)
				REG_CTRL:   dat_o <= {30'h0, highOffset, holdMode};
				REG_DIGITS: dat_o <= {4'h0, digitSwitch};
				REG_STATUS: dat_o <= {28'h0, finalHalvingStage, overflow,
						tuneLower, tuneHigher};
				REG_COUNT:  dat_o <= {4'h0, chain};
				default:    dat_o <= 32'h0;
			endcase
		end
	end

	// Oscillator edge detect and divide by twenty
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			oscPrev  <= 1'b0;
			preCount <= 5'h0;
			preTick  <= 1'b0;
		end else begin
			oscPrev <= variableOscillatorInput;
			preTick <= 1'b0;
			if (variableOscillatorInput && !oscPrev) begin
				if (preCount == 5'(PRESCALE - 1)) begin
					preCount <= 5'h0;
					preTick  <= 1'b1;
				end else begin
					preCount <= preCount + 5'h1;
				end
			end
		end
	end

	// Crystal tick, 50 kHz reference and 50 Hz phase reference
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			xtalCount  <= 5'h0;
			xtalTick   <= 1'b0;
			refCount   <= 7'h0;
			tick50k    <= 1'b0;
			phaseCount <= 10'h0;
			refPulse   <= 1'b0;
		end else begin
			xtalTick <= (xtalCount == 5'(XTAL_DIV - 1));
			xtalCount <= (xtalCount == 5'(XTAL_DIV - 1)) ? 5'h0 : xtalCount + 5'h1;
			tick50k  <= 1'b0;
			refPulse <= 1'b0;
			if (xtalTick) begin
				if (refCount == 7'(REF_DIV - 1)) begin
					refCount <= 7'h0;
					tick50k  <= 1'b1;
					if (phaseCount == 10'(PHASE_DIV - 1)) begin
						phaseCount <= 10'h0;
						refPulse   <= 1'b1;
					end else begin
						phaseCount <= phaseCount + 10'h1;
					end
				end else begin
					refCount <= refCount + 7'h1;
				end
			end
		end
	end

	// Switch wiring gives the nines' complement per digit
	always_comb begin
		for (int d = 0; d < DIGITS; d++) begin
			nineComp[d*4 +: 4] = BCD_NINE - digitSwitch[d*4 +: 4];
		end
	end

	// Offset selection and search-mode digit mask
	assign termBcd  = highOffset ? TERM_HIGH_BCD : TERM_LOW_BCD;
	assign termHalf = highOffset ? TERM_HIGH_HALF : TERM_LOW_HALF;
	assign cmpMask  = searchMode ? 28'hffffff0 : 28'hfffffff;

	// Terminal detector over all stage outputs except the lowest decade in search mode
	assign atTerm = ((chain & cmpMask) == (termBcd & cmpMask))
			&& (finalHalvingStage == termHalf);

	// Stage enables; lowest decade is bypassed in search mode
	assign stageEn[0] = searchMode ? 1'b0 : preTick;
	assign stageEn[1] = searchMode ? preTick : carry[0];
	genvar g;
	generate
		for (g = 2; g < DIGITS; g++) begin : gEn
			assign stageEn[g] = carry[g-1];
		end
	endgenerate

	// Restart the division cycle after reset or a new setting
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			startLoad <= 1'b1;
		end else begin
			startLoad <= wrHit && (adr_i == REG_DIGITS);
		end
	end

	// Preset on terminal count or restart
	assign chainLoad = atTerm || startLoad;

	// Programmable decade chain
	generate
		for (g = 0; g < DIGITS; g++) begin : gDec
			pdtc_decade uDecade (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.load      (chainLoad),
				.loadValue (nineComp[g*4 +: 4]),
				.clear     (1'b0),
				.countEn   (stageEn[g]),
				.digit     (chain[g*4 +: 4]),
				.carry     (carry[g])
			);
		end
	endgenerate

	// Final halving stage and divider output pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			finalHalvingStage <= 1'b0;
			divPulse          <= 1'b0;
		end else begin
			divPulse <= atTerm;
			if (chainLoad) begin
				finalHalvingStage <= 1'b0;
			end else if (carry[DIGITS-1]) begin
				finalHalvingStage <= !finalHalvingStage;
			end
		end
	end

	// Comparison counter enables
	assign cmpEn[0] = searchMode && tick50k;
	assign cmpEn[1] = cmpCarry[0];
	assign cmpEn[2] = cmpCarry[1];

	// Three decade comparison counter, cleared by the divider output
	generate
		for (g = 0; g < CMP_DIGITS; g++) begin : gCmp
			pdtc_decade uCmp (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.load      (1'b0),
				.loadValue (4'h0),
				.clear     (divPulse || holdMode),
				.countEn   (cmpEn[g]),
				.digit     (cmpChain[g*4 +: 4]),
				.carry     (cmpCarry[g])
			);
		end
	endgenerate

	// Overflow flip-flop toggles at each thousandth count
	assign overflowEvt = cmpCarry[CMP_DIGITS-1] && !divPulse;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			overflow <= 1'b0;
		end else if (overflowEvt) begin
			overflow <= !overflow;
		end
	end

	// Retriggerable indicator monostable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			monoCount <= 32'h0;
		end else if (holdMode) begin
			monoCount <= 32'h0;
		end else if (overflowEvt) begin
			monoCount <= 32'(MONO_LEN);
		end else if (monoCount != 32'h0) begin
			monoCount <= monoCount - 32'h1;
		end
	end

	// Lamp drive; in search mode exactly one lamp is lit
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tuneHigher <= 1'b0;
			tuneLower  <= 1'b0;
		end else begin
			tuneHigher <= searchMode && (monoCount != 32'h0) || searchMode && overflowEvt;
			tuneLower  <= searchMode && (monoCount == 32'h0) && !overflowEvt;
		end
	end
endmodule
`default_nettype wire

// >>> bench/pdtc_divider_chk.sv
// Port checker for the divider, bound into every instance.
// Assumes one clock and mode writes seen on the bus ports.
`timescale 1ns/100ps
`default_nettype none
module pdtc_divider_chk
	import pdtc_pkg::*;
#(
	parameter int unsigned MONO_LEN = 200
) (
	// Clock and bus
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [3:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Oscillator and outputs
	input wire logic        variableOscillatorInput,
	input wire logic        divPulse,
	input wire logic        refPulse,
	input wire logic        tuneHigher,
	input wire logic        tuneLower
);
	wire logic   take = cyc_i && stb_i && !ack_o;
	logic        holdMode;
	logic [1:0]  modeAge;
	logic [21:0] sinceDiv;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Mode bit and its age, tracked from bus writes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			holdMode <= 1'b0;
			modeAge  <= 2'h0;
		end else if (ack_o && cyc_i && stb_i && we_i && adr_i == REG_CTRL && sel_i[0]) begin
			holdMode <= dat_i[CTRL_HOLD_BIT];
			modeAge  <= 2'h0;
		end else if (modeAge != 2'h3) begin
			modeAge <= modeAge + 2'h1;
		end
	end
	// Cycles since the last divider pulse, saturating
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sinceDiv <= 22'h0;
		end else if (divPulse) begin
			sinceDiv <= 22'h0;
		end else if (sinceDiv != 22'h3fffff) begin
			sinceDiv <= sinceDiv + 22'h1;
		end
	end
	// Bus timing, lamps, pulses
	property p_ack_next; take |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("late ack");
	property p_ack_once; ack_o |=> !ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("long ack");
	property p_unmapped; take && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_lamp_excl; !(tuneHigher && tuneLower); endproperty
	a_lamp_excl: assert property (p_lamp_excl) else $error("both lamps lit");
	property p_hold_dark; holdMode && modeAge == 2'h3 |-> !tuneHigher && !tuneLower; endproperty
	a_hold_dark: assert property (p_hold_dark) else $error("lamp lit in hold");
	property p_search_lit; !holdMode && modeAge == 2'h3 |-> tuneHigher || tuneLower; endproperty
	a_search_lit: assert property (p_search_lit) else $error("no lamp in search");
	property p_div_once; divPulse |=> !divPulse; endproperty
	a_div_once: assert property (p_div_once) else $error("long div pulse");
	property p_div_gap; divPulse |-> sinceDiv >= 22'h26; endproperty
	a_div_gap: assert property (p_div_gap) else $error("div pulses too close");
	property p_ref_once; refPulse |=> !refPulse; endproperty
	a_ref_once: assert property (p_ref_once) else $error("long ref pulse");
	property p_higher_late; $rose(tuneHigher) |-> sinceDiv >= 22'h1e0000; endproperty
	a_higher_late: assert property (p_higher_late) else $error("early higher");
endmodule
bind pdtc_divider pdtc_divider_chk #(.MONO_LEN(MONO_LEN)) u_pdtc_divider_chk (
	.mclk(mclk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.variableOscillatorInput(variableOscillatorInput), .divPulse(divPulse),
	.refPulse(refPulse), .tuneHigher(tuneHigher), .tuneLower(tuneLower)
);
`default_nettype wire

// >>> bench/pdtc_osc_model.sv
// Receiver oscillator model sending bursts of square-wave cycles.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module pdtc_osc_model (
	// Clock
	input  wire logic mclk,
	// Oscillator line
	output logic      osc
);
	initial osc = 1'b0;
	// Line stands low between bursts, as a stopped oscillator
	task automatic send(input int cycles, input int half);
		repeat (cycles) begin
			osc <= 1'b1;
			repeat (half) @(posedge mclk);
			osc <= 1'b0;
			repeat (half) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Bench for the divider: register access and prescaled chain counting.
// Assumes the oscillator model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pdtc_pkg::*;
	logic        mclk       = 1'b0;
	logic        reset_n    = 1'b0;
	logic        cyc        = 1'b0;
	logic        we         = 1'b0;
	logic [3:0]  adr        = 4'h0;
	logic [31:0] wdat       = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        osc;
	logic        divPulse;
	logic [31:0] divCount   = 32'h0;
	int          errorCnt   = 0;
	int          checkCount = 0;
	// Free-running 100 MHz clock
	always #5 mclk = ~mclk;
	// Device and oscillator
	pdtc_divider #(.MONO_LEN(200)) u_pdtc_divider (
		.mclk(mclk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.variableOscillatorInput(osc), .divPulse(divPulse), .refPulse(), .tuneHigher(),
		.tuneLower()
	);
	pdtc_osc_model u_pdtc_osc_model (.mclk(mclk), .osc(osc));
	// Divider pulses seen at the port
	always @(posedge mclk) begin
		if (divPulse === 1'b1) begin
			divCount <= divCount + 32'h1;
		end
	end
	// Compare one word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One classic bus cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge mclk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	// Reset values, search mode lights the lower lamp
	task automatic tResetValues();
		rd(REG_CTRL, 32'h3, 32'h0);
		rd(REG_DIGITS, 32'h0fffffff, 32'h0);
		rd(REG_COUNT, 32'hffffffff, 32'h09999999);
		rd(REG_STATUS, 32'hf, 32'h2);
	endtask
	// Digits, mode, unmapped and read-only places
	task automatic tRegisters();
		wr(REG_DIGITS, 32'h00214010);
		rd(REG_DIGITS, 32'h0fffffff, 32'h00214010);
		wr(REG_CTRL, 32'h3);
		rd(REG_CTRL, 32'h3, 32'h3);
		repeat (4) @(posedge mclk);
		rd(REG_STATUS, 32'h3, 32'h0);
		wr(4'h2, 32'hffffffff);
		rd(4'h2, 32'hffffffff, 32'h0);
		wr(REG_COUNT, 32'h05555555);
		rd(REG_COUNT, 32'hffffffff, 32'h09785989);
	endtask
	// Hold mode: twenty edges per tick, decade carry
	task automatic tHoldCount();
		u_pdtc_osc_model.send(19, 2);
		rd(REG_COUNT, 32'hffffffff, 32'h09785989);
		u_pdtc_osc_model.send(1, 2);
		rd(REG_COUNT, 32'hffffffff, 32'h09785990);
		u_pdtc_osc_model.send(220, 5);
		rd(REG_COUNT, 32'hffffffff, 32'h09786001);
	endtask
	// Hold, low offset: three ticks to terminal, pulse and reload
	task automatic tDivide();
		wr(REG_CTRL, 32'h1);
		wr(REG_DIGITS, 32'h00214003);
		rd(REG_COUNT, 32'hffffffff, 32'h09785996);
		u_pdtc_osc_model.send(60, 2);
		chk(divCount, 32'h1);
		rd(REG_COUNT, 32'hffffffff, 32'h09785996);
		rd(REG_STATUS, 32'hb, 32'h0);
		u_pdtc_osc_model.send(60, 2);
		chk(divCount, 32'h2);
	endtask
	// Search mode: lowest decade bypassed, then a masked terminal
	task automatic tSearchCount();
		wr(REG_CTRL, 32'h2);
		repeat (4) @(posedge mclk);
		rd(REG_STATUS, 32'h3, 32'h2);
		u_pdtc_osc_model.send(40, 2);
		rd(REG_COUNT, 32'hfffffff0, 32'h09786010);
		wr(REG_CTRL, 32'h0);
		wr(REG_DIGITS, 32'h00214020);
		u_pdtc_osc_model.send(40, 2);
		chk(divCount, 32'h3);
		rd(REG_COUNT, 32'hffffffff, 32'h09785979);
	endtask
	// Verdict and end of run
	task automatic endSim();
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		tResetValues();
		tRegisters();
		tHoldCount();
		tDivide();
		tSearchCount();
		endSim();
	end
	// Watchdog, about 50000 cycles
	initial begin
		#500000;
		errorCnt++;
		endSim();
	end
endmodule
`default_nettype wire
